// File: design/scg_top.sv
// System clock generation: source select, divider, wake-up and clock out
`default_nettype none
module scg_top (
	input  wire logic            clk,
	input  wire logic            reset,
	input  wire logic            power_on_reset,
	input  wire scg_pkg::scg_src_e osc_config,
	input  wire logic            rtc_uses_crystal,
	input  wire logic            xtal_osc_tick,
	input  wire logic            internal_rc_clock,
	input  wire logic            wdog_osc_tick,
	input  wire logic            crystal_in_pin,
	input  wire logic            port_pin_out,
	input  wire scg_pkg::scg_bus_s bus,
	output logic [7:0]           rdata,
	output scg_pkg::scg_clk_s    clocks,
	output logic                 osc_source_clock,
	output logic [2:0]           xtal_range,
	output logic [5:0]           rc_trim,
	output logic                 low_power_clock_select,
	output logic                 crystal_out_clock_pin,
	output logic                 crystal_out_oe_n,
	output logic                 external_reset_pin_required
);
	import scg_pkg::*;

	// ----------------------------------------------------------------
	// Configuration capture
	// ----------------------------------------------------------------
	scg_src_e   source;
	logic       xtal_mode;
	logic       next_osc_tick;
	logic       cpu_tick;
	logic       wake_ready;
	logic       phase;
	logic       clkout_level;
	logic [7:0] rc_osc_tune;
	logic [7:0] clock_divide_value;
	logic [7:0] aux_function_reg_one;

	// Latched at reset so a flip of the straps mid-run has no effect
	always_ff @(posedge clk) begin
		if (reset || power_on_reset)
			source <= osc_config;
	end

	// Any crystal range counts as crystal in use
	always_comb begin
		xtal_mode = (source == SCG_SRC_XTAL_LOW) || (source == SCG_SRC_XTAL_MED)
		         || (source == SCG_SRC_XTAL_HIGH);
	end

	// Range code handed to the analogue oscillator cell
	always_ff @(posedge clk) begin
		if (reset) begin
			xtal_range <= 3'h0;
		end else begin
			xtal_range[0] <= source == SCG_SRC_XTAL_LOW;
			xtal_range[1] <= source == SCG_SRC_XTAL_MED;
			xtal_range[2] <= source == SCG_SRC_XTAL_HIGH;
		end
	end

	// ----------------------------------------------------------------
	// Oscillator source mux
	// ----------------------------------------------------------------
	// Sources arrive as ticks in the system clock; the watchdog one is
	// never gated, it keeps running for the watchdog itself
	always_comb begin
		case (source)
			SCG_SRC_XTAL_LOW,
			SCG_SRC_XTAL_MED,
			SCG_SRC_XTAL_HIGH: next_osc_tick = xtal_osc_tick;
			SCG_SRC_RC:        next_osc_tick = internal_rc_clock && rc_osc_tune[BIT_RC_SELECT];
			SCG_SRC_WDOG:      next_osc_tick = wdog_osc_tick;
			SCG_SRC_EXT:       next_osc_tick = crystal_in_pin;
			default:           next_osc_tick = internal_rc_clock;
		endcase
	end

	// Registered oscillator tick
	always_ff @(posedge clk) begin
		if (reset)
			osc_source_clock <= 1'b0;
		else
			osc_source_clock <= next_osc_tick;
	end

	// ----------------------------------------------------------------
	// Wake-up and divider
	// ----------------------------------------------------------------
	scg_wake_timer u_wake (
		.clk       (clk),
		.reset     (reset),
		.osc_tick  (osc_source_clock),
		.xtal_mode (xtal_mode),
		.ready     (wake_ready)
	);

	scg_divider u_div (
		.clk                (clk),
		.reset              (reset),
		.osc_tick           (osc_source_clock),
		.run                (wake_ready),
		.clock_divide_value (clock_divide_value),
		.cpu_tick           (cpu_tick)
	);

	// ----------------------------------------------------------------
	// Derived clocks
	// ----------------------------------------------------------------
	// One phase bit serves both machine cycle and peripheral clock
	always_ff @(posedge clk) begin
		if (reset) begin
			phase  <= 1'b0;
			clocks <= '0;
		end else begin
			clocks.cpu_core_clock <= cpu_tick;
			clocks.periph_clock   <= cpu_tick && phase;
			clocks.machine_cycle  <= cpu_tick && phase;
			if (cpu_tick)
				phase <= ~phase;
		end
	end

	// ----------------------------------------------------------------
	// Clock output pin
	// ----------------------------------------------------------------
	// Toggles once per CPU clock, giving half its rate on the pin
	always_ff @(posedge clk) begin
		if (reset)
			clkout_level <= 1'b0;
		else if (cpu_tick)
			clkout_level <= ~clkout_level;
	end

	// Crystal owns the pin when in use; otherwise port or clock out
	always_ff @(posedge clk) begin
		if (reset) begin
			crystal_out_clock_pin <= 1'b0;
			crystal_out_oe_n      <= 1'b1;
		end else if (xtal_mode || rtc_uses_crystal) begin
			crystal_out_clock_pin <= 1'b0;
			crystal_out_oe_n      <= 1'b1;
		end else if (rc_osc_tune[BIT_CLKOUT_EN]) begin
			crystal_out_clock_pin <= clkout_level;
			crystal_out_oe_n      <= 1'b0;
		end else begin
			crystal_out_clock_pin <= port_pin_out;
			crystal_out_oe_n      <= 1'b0;
		end
	end

	// Flag for the reset pin logic; the system must honour it
	always_ff @(posedge clk) begin
		if (reset)
			external_reset_pin_required <= 1'b0;
		else
			external_reset_pin_required <= source == SCG_SRC_EXT;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Tune survives warm resets; only power-on reloads the factory value
	always_ff @(posedge clk) begin
		if (power_on_reset)
			rc_osc_tune <= {1'b1, 1'b0, TUNE_FACTORY};
		else if (bus.wr && bus.addr == ADDR_RC_OSC_TUNE)
			rc_osc_tune <= bus.wdata;
	end

	// Divider written any time; the divider follows on its next tick
	always_ff @(posedge clk) begin
		if (reset || power_on_reset)
			clock_divide_value <= DIVIDE_RESET;
		else if (bus.wr && bus.addr == ADDR_CLOCK_DIVIDE)
			clock_divide_value <= bus.wdata;
	end

	// Low-power bit cleared on every reset source
	always_ff @(posedge clk) begin
		if (reset || power_on_reset)
			aux_function_reg_one <= ZERO_BYTE;
		else if (bus.wr && bus.addr == ADDR_AUX_FUNC_ONE)
			aux_function_reg_one <= bus.wdata;
	end

	// Live views of the stored fields
	always_comb begin
		rc_trim                = rc_osc_tune[TUNE_MSB:0];
		low_power_clock_select = aux_function_reg_one[BIT_LOW_POWER];
	end

	// Read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata <= ZERO_BYTE;
		end else if (bus.rd) begin
			case (bus.addr)
				ADDR_RC_OSC_TUNE:  rdata <= rc_osc_tune;
				ADDR_CLOCK_DIVIDE: rdata <= clock_divide_value;
				ADDR_AUX_FUNC_ONE: rdata <= aux_function_reg_one;
				ADDR_CLOCK_STATUS: rdata <= {3'h0, wake_ready, xtal_mode, source};
				default:           rdata <= ZERO_BYTE;
			endcase
		end else begin
			rdata <= ZERO_BYTE;
		end
	end
endmodule
`default_nettype wire

// File: design/scg_pkg.sv
// Package for the system clock generation block: offsets, fields, modes
`default_nettype none
package scg_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_RC_OSC_TUNE   = 8'h96;
	localparam logic [7:0] ADDR_CLOCK_DIVIDE  = 8'h95;
	localparam logic [7:0] ADDR_AUX_FUNC_ONE  = 8'ha2;
	localparam logic [7:0] ADDR_CLOCK_STATUS  = 8'hf0;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_RC_SELECT   = 7;
	localparam int BIT_CLKOUT_EN   = 6;
	localparam int TUNE_MSB        = 5;
	localparam int BIT_LOW_POWER   = 7;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [5:0] TUNE_FACTORY   = 6'h20;
	localparam logic [7:0] DIVIDE_RESET   = 8'h00;
	localparam logic [7:0] ZERO_BYTE      = 8'h00;

	// ----------------------------------------------------------------
	// Wake-up timing
	// ----------------------------------------------------------------
	localparam int WAKE_XTAL_OSC_CYCLES  = 992;
	localparam int WAKE_OTHER_OSC_CYCLES = 224;
	localparam int WAKE_EXTRA_US         = 100;
	localparam int CLK_MHZ               = 50;
	localparam int WAKE_EXTRA_CYCLES     = WAKE_EXTRA_US * CLK_MHZ;
	localparam int WAKE_CNT_W            = 13;

	// ----------------------------------------------------------------
	// Oscillator source configuration
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SCG_SRC_XTAL_LOW  = 3'h0,
		SCG_SRC_XTAL_MED  = 3'h1,
		SCG_SRC_XTAL_HIGH = 3'h2,
		SCG_SRC_RC        = 3'h3,
		SCG_SRC_WDOG      = 3'h4,
		SCG_SRC_EXT       = 3'h7
	} scg_src_e;

	// Register bus request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} scg_bus_s;

	// Derived clock enables
	typedef struct packed {
		logic cpu_core_clock;
		logic periph_clock;
		logic machine_cycle;
	} scg_clk_s;
endpackage
`default_nettype wire

// File: design/scg_divider.sv
// Divider producing CPU clock enables from the oscillator source ticks
`default_nettype none
module scg_divider (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       osc_tick,
	input  wire logic       run,
	input  wire logic [7:0] clock_divide_value,
	output logic            cpu_tick
);
	import scg_pkg::*;

	logic [8:0] count;
	logic [8:0] limit;

	// Zero passes straight through; N divides by 2N
	always_comb begin
		limit = {clock_divide_value, 1'b0} - 9'h001;
	end

	// Counter compares against the live value so changes apply at once
	always_ff @(posedge clk) begin
		if (reset) begin
			count    <= 9'h000;
			cpu_tick <= 1'b0;
		end else begin
			cpu_tick <= 1'b0;
			if (run && osc_tick) begin
				if (clock_divide_value == DIVIDE_RESET || count >= limit) begin
					count    <= 9'h000;
					cpu_tick <= 1'b1;
				end else begin
					count <= count + 9'h001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: design/scg_wake_timer.sv
// Wake-up delay timer: oscillator cycle count then microsecond settle
`default_nettype none
module scg_wake_timer (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic osc_tick,
	input  wire logic xtal_mode,
	output logic      ready
);
	import scg_pkg::*;

	logic [WAKE_CNT_W-1:0] osc_count;
	logic [WAKE_CNT_W-1:0] us_count;
	logic [WAKE_CNT_W-1:0] osc_target;

	// Crystal needs the long count, others the short one
	always_comb begin
		osc_target = xtal_mode ? WAKE_CNT_W'(WAKE_XTAL_OSC_CYCLES)
		                       : WAKE_CNT_W'(WAKE_OTHER_OSC_CYCLES);
	end

	// Upper settle bound used, so the clock is never released early
	always_ff @(posedge clk) begin
		if (reset) begin
			osc_count <= '0;
			us_count  <= '0;
			ready     <= 1'b0;
		end else if (!ready) begin
			if (osc_count < osc_target) begin
				if (osc_tick)
					osc_count <= osc_count + 1'b1;
			end else if (us_count < WAKE_CNT_W'(WAKE_EXTRA_CYCLES)) begin
				us_count <= us_count + 1'b1;
			end else begin
				ready <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: testbench/scg_top_properties.sv
// Checker for bus answers, reset behaviour and clock relations
`default_nettype none
module scg_top_properties (
	input wire logic              clk,
	input wire logic              reset,
	input wire logic              power_on_reset,
	input wire logic              rtc_uses_crystal,
	input wire scg_pkg::scg_bus_s bus,
	input wire logic [7:0]        rdata,
	input wire scg_pkg::scg_clk_s clocks,
	input wire logic [2:0]        xtal_range,
	input wire logic [5:0]        rc_trim,
	input wire logic              low_power_clock_select,
	input wire logic              crystal_out_oe_n
);
	import scg_pkg::*;
	// ----
	// Bus answers
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_rd(a);
		bus.rd && bus.addr == a;
	endsequence
	a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
		else $error("read data outside answer cycle");
	a_rd_trim: assert property (s_rd(ADDR_RC_OSC_TUNE) |=> rdata[5:0] == $past(rc_trim))
		else $error("tune read mismatch");
	a_rd_lp: assert property (s_rd(ADDR_AUX_FUNC_ONE)
		|=> rdata[7] == $past(low_power_clock_select))
		else $error("low power read mismatch");
	// ----------------------------------------------------------------
	// Reset handling; warm reset must not touch the trim
	// ----------------------------------------------------------------
	a_lp_reset: assert property ($past(reset) |-> !low_power_clock_select)
		else $error("low power bit not cleared");
	a_lp_hold: assert property (!$past(reset) && !$past(power_on_reset)
		&& !($past(bus.wr) && $past(bus.addr) == ADDR_AUX_FUNC_ONE)
		|-> $stable(low_power_clock_select))
		else $error("low power bit changed without write");
	a_trim_warm: assert property (@(posedge clk) disable iff (power_on_reset)
		reset |=> $stable(rc_trim))
		else $error("trim changed by warm reset");
	// ----------------------------------------------------------------
	// Derived clocks and clock out
	// ----------------------------------------------------------------
	a_mc_periph: assert property (clocks.machine_cycle == clocks.periph_clock)
		else $error("peripheral clock differs from machine cycle");
	a_mc_with: assert property (clocks.machine_cycle |-> clocks.cpu_core_clock)
		else $error("machine cycle without cpu tick");
	a_oe_xtal: assert property (xtal_range != 3'h0 |-> crystal_out_oe_n)
		else $error("clock out driven in crystal mode");
	a_oe_rtc: assert property (rtc_uses_crystal [*2] |-> crystal_out_oe_n)
		else $error("clock out driven while rtc uses crystal");
endmodule
bind scg_top scg_top_properties scg_top_properties_inst (.clk, .reset, .power_on_reset,
	.rtc_uses_crystal, .bus, .rdata, .clocks, .xtal_range, .rc_trim,
	.low_power_clock_select, .crystal_out_oe_n);
`default_nettype wire

// File: testbench/test_system_clock_generation.sv
// Self-checking bench for the system clock generation block
`default_nettype none
module test_system_clock_generation;
	timeunit 1ns;
	timeprecision 1ns;
	import scg_pkg::*;
	logic       clk = 0, reset = 1, power_on_reset = 1, rtc_uses_crystal = 0;
	logic       tk = 0, port_pin_out = 0, p, osc_clk;
	scg_src_e   osc_config = SCG_SRC_RC;
	scg_bus_s   bus = '0;
	logic [7:0] rdata;
	scg_clk_s   clocks;
	logic       low_power_clock_select, crystal_out_clock_pin;
	logic       crystal_out_oe_n, external_reset_pin_required;
	logic [2:0] xtal_range;
	logic [5:0] rc_trim;
	int         mismatches = 0, cmp_count = 0, n, m;
	int         dv [3] = '{0, 1, 255};
	scg_src_e   src [6] = '{SCG_SRC_XTAL_LOW, SCG_SRC_XTAL_MED, SCG_SRC_XTAL_HIGH,
		SCG_SRC_RC, SCG_SRC_WDOG, SCG_SRC_EXT};
	scg_top scg_top_inst (.clk, .reset, .power_on_reset, .osc_config, .rtc_uses_crystal,
		.xtal_osc_tick(tk), .internal_rc_clock(tk), .wdog_osc_tick(tk),
		.crystal_in_pin(tk), .port_pin_out, .bus, .rdata, .clocks, .osc_source_clock(osc_clk),
		.xtal_range, .rc_trim, .low_power_clock_select, .crystal_out_clock_pin,
		.crystal_out_oe_n, .external_reset_pin_required);
	// Clock, and one oscillator tick every second cycle
	always #10 clk = ~clk;
	always @(posedge clk) tk <= ~tk;
	// ----
	// Access and compare tasks
	// ----
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) bus <= '{1'b1, 1'b0, a, d};
		@(posedge clk) bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk) bus <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk) bus.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task automatic rst(input logic por, input scg_src_e cfg);
		@(posedge clk) reset <= 1'b1;
		power_on_reset <= por;
		osc_config <= cfg;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		power_on_reset <= 1'b0;
	endtask
	// Cycles between two pulses; bounded so a stuck divider cannot hang
	task automatic gap(input logic mc, input int exp);
		int c;
		c = 0;
		// Look only at settled values, never at the launching edge
		#1;
		while ((mc ? clocks.machine_cycle : clocks.cpu_core_clock) !== 1'b1 && c < 3000) begin
			@(posedge clk) #1 c++;
		end
		c = 0;
		do @(posedge clk) #1 c++;
		while ((mc ? clocks.machine_cycle : clocks.cpu_core_clock) !== 1'b1 && c < 3000);
		chk(8'(c >> 8), 8'(exp >> 8));
		chk(8'(c), 8'(exp));
	endtask
	task automatic end_sim;
		if (mismatches == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ----
	// Main sequence
	// ----
	initial begin
		rst(1'b1, SCG_SRC_RC);
		rd(ADDR_RC_OSC_TUNE, {2'b10, TUNE_FACTORY});
		rd(ADDR_AUX_FUNC_ONE, 8'h00);
		rd(ADDR_CLOCK_DIVIDE, DIVIDE_RESET);
		rd(8'h55, 8'h00);
		wr(ADDR_CLOCK_STATUS, 8'hff);
		rd(ADDR_CLOCK_STATUS, 8'h03);
		repeat (5200) @(posedge clk);
		rd(ADDR_CLOCK_STATUS, 8'h03);
		repeat (400) @(posedge clk);
		rd(ADDR_CLOCK_STATUS, 8'h13);
		wr(ADDR_AUX_FUNC_ONE, 8'h80);
		rd(ADDR_AUX_FUNC_ONE, 8'h80);
		chk(8'(low_power_clock_select), 8'h01);
		foreach (dv[i]) begin
			wr(ADDR_CLOCK_DIVIDE, 8'(dv[i]));
			gap(1'b0, dv[i] == 0 ? 2 : 4 * dv[i]);
			gap(1'b1, dv[i] == 0 ? 4 : 8 * dv[i]);
		end
		wr(ADDR_CLOCK_DIVIDE, 8'h00);
		wr(ADDR_RC_OSC_TUNE, 8'hc5);
		repeat (3) @(posedge clk);
		#1 chk(8'(crystal_out_oe_n), 8'h00);
		chk(8'(rc_trim), 8'h05);
		n = 0;
		m = 0;
		p = crystal_out_clock_pin;
		// Pin toggles and source ticks counted over the same window
		repeat (32) begin
			@(posedge clk) #1 n += (crystal_out_clock_pin !== p);
			m += (osc_clk === 1'b1);
			p = crystal_out_clock_pin;
		end
		chk(8'(n), 8'd16);
		chk(8'(m), 8'd16);
		rtc_uses_crystal <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(8'(crystal_out_oe_n), 8'h01);
		rtc_uses_crystal <= 1'b0;
		wr(ADDR_RC_OSC_TUNE, 8'h85);
		port_pin_out <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(8'({crystal_out_oe_n, crystal_out_clock_pin}), 8'h01);
		wr(ADDR_RC_OSC_TUNE, 8'hc5);
		rst(1'b0, SCG_SRC_XTAL_HIGH);
		rd(ADDR_RC_OSC_TUNE, 8'hc5);
		rd(ADDR_AUX_FUNC_ONE, 8'h00);
		chk(8'(low_power_clock_select), 8'h00);
		chk(8'({crystal_out_oe_n, xtal_range}), 8'h0c);
		repeat (6850) @(posedge clk);
		rd(ADDR_CLOCK_STATUS, 8'h0a);
		repeat (300) @(posedge clk);
		rd(ADDR_CLOCK_STATUS, 8'h1a);
		foreach (src[i]) begin
			rst(1'b0, src[i]);
			rd(ADDR_CLOCK_STATUS, {4'h0, src[i] < 3, src[i]});
			chk(8'(xtal_range), 8'(src[i] < 3 ? 3'h1 << src[i] : 3'h0));
			chk(8'(external_reset_pin_required), 8'(src[i] == SCG_SRC_EXT));
		end
		end_sim();
	end
	// Watchdog: the run needs about 20000 cycles
	initial begin
		#800000;
		mismatches++;
		end_sim();
	end
endmodule
`default_nettype wire
